// file: common/timer_pkg.sv
/*
  Package for the window, capture and pulse generator timer block.
  Holds register offsets, control field layout, mode and start codes,
  prescaler taps and the bus request carrier. Assumes a single 100 MHz clock.
*/
package timer_pkg;

  // Register byte offsets on the plain register port.
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] PERIOD_OFS = 8'h04;
  localparam logic [7:0] DUTY_OFS   = 8'h08;
  localparam logic [7:0] COUNT_OFS  = 8'h0C;

  // Data width of counter, compare and capture registers.
  localparam int CNT_W = 16;

  // Codes of the mode field.
  localparam logic [2:0] MODE_TIMER   = 3'h0;
  localparam logic [2:0] MODE_WINDOW  = 3'h3;
  localparam logic [2:0] MODE_MEASURE = 3'h4;
  localparam logic [2:0] MODE_PULSE   = 3'h6;

  // Codes of the start-edge select field.
  localparam logic [1:0] SEL_STOP = 2'h0;
  localparam logic [1:0] SEL_CMD  = 2'h1;
  localparam logic [1:0] SEL_RISE = 2'h2;
  localparam logic [1:0] SEL_FALL = 2'h3;

  // Prescaler width and the divide exponent of each source clock select code.
  localparam int PRESC_W = 11;
  localparam int TAP0    = 11;
  localparam int TAP1    = 7;
  localparam int TAP2    = 3;
  localparam int TAP3    = 1;

  // Control register layout, bit 15 down to bit 0.
  typedef struct packed {
    logic [5:0] spare;
    logic       output_initial_level;
    logic       pulse_repeat_mode;
    logic       capture_edge_mode;
    logic [1:0] source_clock_select;
    logic [2:0] mode_field;
    logic [1:0] start_edge_select;
  } ctrl_t;

  localparam logic [15:0] CTRL_RST = 16'h0000;

  // One register port request.
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  // Counter sequencing states.
  typedef enum logic [1:0] {ST_STOP, ST_WAIT, ST_RUN} run_state_t;

endpackage : timer_pkg

// file: rtl/timer_window_capture_pulse_gen.sv
/*
  Sixteen-bit up-counting timer with window count, pulse width capture and
  programmable pulse output modes, reached over a plain register port.
  Assumes the timer input pin is asynchronous and the bus master is on i_clk.
*/
// Function
// - Window mode counts rising edges of pin level ANDed with source clock.
// - Select code 10 counts while pin high, 11 while pin low.
// - Window counter equal to period raises interrupt and clears counter.
// - Measurement starts counting at selected trigger edge, then counts source clock.
// - Capture mode bit 1 is single-edge capture, 0 is double-edge capture.
// - Single-edge: opposite edge captures, interrupts, sets counter to one, waits for next trigger.
// - Single-edge: counter holds at one after capture until next trigger.
// - Double-edge: capture at both edges, clear at trigger, keep counting.
// - Pulse mode starts on pin edge or command; repeat bit picks one-shot.
// - Continuous pulse toggles at duty match, toggles and clears at period.
// - Writing stop during pulse output stops counter, output level held.
// - One-shot toggles at both matches, then clears select and stops.
// - Output pin is inverse of flop; initial bit sets start level; reset clears.
`timescale 1ns/1ps
`default_nettype none

module timer_window_capture_pulse_gen #(
  parameter int CNT_W = timer_pkg::CNT_W
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire timer_pkg::bus_req_t  i_bus,
  output logic [15:0]               o_rdata,
  input  wire logic                 i_timer_input_pin,
  output logic                      o_pulse_out_pin_n,
  output logic                      o_timer_match_irq
);

  timer_pkg::ctrl_t        ctrl_reg;
  timer_pkg::ctrl_t        wr_ctrl;
  timer_pkg::run_state_t   state_reg;
  logic [CNT_W-1:0]        cnt_reg;
  logic [CNT_W-1:0]        period_compare_reg;
  logic [CNT_W-1:0]        capture_duty_reg;
  logic [15:0]             rdata_reg;
  logic                    irq_reg;
  logic                    output_toggle_flop;
  logic                    armed_reg;
  logic                    pin_s1_reg;
  logic                    pin_s2_reg;
  logic                    pin_d_reg;
  logic [timer_pkg::PRESC_W-1:0] presc_reg;
  logic                    src_d_reg;
  logic                    gate_d_reg;
  logic                    src_lvl;
  logic                    tick;
  logic                    gate;
  logic                    gtick;
  logic                    rise;
  logic                    fall;
  logic                    trig;
  logic                    opp;
  logic                    running;
  logic                    live;
  logic                    win;
  logic                    meas;
  logic                    pulse;
  logic                    single;
  logic                    ctrl_wr;
  logic                    win_match;
  logic                    m_duty;
  logic                    m_per;
  logic                    cap_ev;
  logic                    oneshot_done;

  // Two-stage synchroniser for the pin, then a third stage for edge detection.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_d_reg  <= 1'b0;
    end else begin
      pin_s1_reg <= i_timer_input_pin;
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg  <= pin_s2_reg;
    end
  end

  // Free-running prescaler and delayed copies for rising-edge detection.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      presc_reg  <= '0;
      src_d_reg  <= 1'b0;
      gate_d_reg <= 1'b0;
    end else begin
      presc_reg  <= presc_reg + 1'b1;
      src_d_reg  <= src_lvl;
      gate_d_reg <= gate;
    end
  end

  // Source clock level picked from the prescaler tap of the selected divide.
  always_comb begin
    case (ctrl_reg.source_clock_select)
      2'h0:    src_lvl = presc_reg[timer_pkg::TAP0-1];
      2'h1:    src_lvl = presc_reg[timer_pkg::TAP1-1];
      2'h2:    src_lvl = presc_reg[timer_pkg::TAP2-1];
      default: src_lvl = presc_reg[timer_pkg::TAP3-1];
    endcase
  end

  // Decoded modes, edges and the window gate.
  assign running = (ctrl_reg.start_edge_select != timer_pkg::SEL_STOP);
  assign win     = (ctrl_reg.mode_field == timer_pkg::MODE_WINDOW);
  assign meas    = (ctrl_reg.mode_field == timer_pkg::MODE_MEASURE);
  assign pulse   = (ctrl_reg.mode_field == timer_pkg::MODE_PULSE);
  assign single  = ctrl_reg.capture_edge_mode;
  assign tick    = src_lvl & ~src_d_reg;
  assign rise    = pin_s2_reg & ~pin_d_reg;
  assign fall    = ~pin_s2_reg & pin_d_reg;
  assign trig    = (ctrl_reg.start_edge_select == timer_pkg::SEL_FALL) ? fall : rise;
  assign opp     = (ctrl_reg.start_edge_select == timer_pkg::SEL_FALL) ? rise : fall;
  assign ctrl_wr = i_bus.wr && (i_bus.addr == timer_pkg::CTRL_OFS);
  assign wr_ctrl = i_bus.wdata;  // Write data seen through the control field layout.

  // The window gate follows the pin high for code 10 and low for code 11.
  assign gate  = src_lvl & ((ctrl_reg.start_edge_select == timer_pkg::SEL_RISE) ? pin_s2_reg :
                            (ctrl_reg.start_edge_select == timer_pkg::SEL_FALL) ? ~pin_s2_reg : 1'b0);
  assign gtick = gate & ~gate_d_reg;

  // Compare and capture events; all compares use the full counter width.
  // Events need a running select field, so a stop write freezes the output from the cycle after its strobe.
  assign live         = running && (state_reg == timer_pkg::ST_RUN);
  assign win_match    = win && live && gtick && (cnt_reg == period_compare_reg);
  assign m_duty       = pulse && live && tick && (cnt_reg == capture_duty_reg);
  assign m_per        = pulse && live && tick && (cnt_reg == period_compare_reg);
  assign cap_ev       = meas && live && (opp || (!single && trig));
  assign oneshot_done = m_per && ctrl_reg.pulse_repeat_mode;

  // Control register; a one-shot end clears the select field unless software writes.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_reg <= timer_pkg::CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_reg <= wr_ctrl;
    end else if (oneshot_done) begin
      ctrl_reg.start_edge_select <= timer_pkg::SEL_STOP;
    end
  end

  // Period compare register, written only by software.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      period_compare_reg <= '0;
    end else if (i_bus.wr && (i_bus.addr == timer_pkg::PERIOD_OFS)) begin
      period_compare_reg <= i_bus.wdata[CNT_W-1:0];
    end
  end

  // Capture or duty register; a capture wins over a software write.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      capture_duty_reg <= '0;
    end else if (cap_ev) begin
      capture_duty_reg <= cnt_reg;
    end else if (i_bus.wr && (i_bus.addr == timer_pkg::DUTY_OFS)) begin
      capture_duty_reg <= i_bus.wdata[CNT_W-1:0];
    end
  end

  // Counter and its run state for all three modes.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= timer_pkg::ST_STOP;
      cnt_reg   <= '0;
    end else if (!running || !(win || meas || pulse)) begin
      state_reg <= timer_pkg::ST_STOP;
      cnt_reg   <= '0;
    end else begin
      case (state_reg)
        timer_pkg::ST_STOP: begin
          cnt_reg <= '0;
          if (win || (pulse && ctrl_reg.start_edge_select == timer_pkg::SEL_CMD)) begin
            state_reg <= timer_pkg::ST_RUN;
          end else begin
            state_reg <= timer_pkg::ST_WAIT;
          end
        end
        timer_pkg::ST_WAIT: begin
          if (trig || (pulse && ctrl_reg.start_edge_select == timer_pkg::SEL_CMD)) begin
            state_reg <= timer_pkg::ST_RUN;
          end
        end
        default: begin
          if (win) begin
            if (win_match) begin
              cnt_reg <= '0;
            end else if (gtick) begin
              cnt_reg <= cnt_reg + 1'b1;
            end
          end else if (meas) begin
            if (opp && single) begin
              cnt_reg   <= {{(CNT_W-1){1'b0}}, 1'b1};
              state_reg <= timer_pkg::ST_WAIT;
            end else if (trig && !single) begin
              cnt_reg <= '0;
            end else if (tick) begin
              cnt_reg <= cnt_reg + 1'b1;
            end
          end else begin
            if (m_per) begin
              cnt_reg <= '0;
              if (ctrl_reg.pulse_repeat_mode) begin
                state_reg <= timer_pkg::ST_STOP;
              end
            end else if (tick) begin
              cnt_reg <= cnt_reg + 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Arming: the flop may be initialised after leaving pulse mode and before a run.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      armed_reg <= 1'b1;
    end else if (!pulse) begin
      armed_reg <= 1'b1;
    end else if (state_reg == timer_pkg::ST_RUN) begin
      armed_reg <= 1'b0;
    end
  end

  // Output flop: initial level on an armed pulse-mode write, toggles on matches.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      output_toggle_flop <= 1'b0;
    end else if (m_duty || m_per) begin
      output_toggle_flop <= ~output_toggle_flop;
    end else if (ctrl_wr && armed_reg && (wr_ctrl.mode_field == timer_pkg::MODE_PULSE)) begin
      output_toggle_flop <= wr_ctrl.output_initial_level;
    end
  end

  // Shared interrupt pulse for window match, capture and both pulse matches.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= win_match || cap_ev || m_duty || m_per;
    end
  end

  // Read data, valid in the cycle after the read strobe; unmapped reads give zero.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_reg <= 16'h0000;
    end else if (i_bus.rd) begin
      if (i_bus.addr == timer_pkg::CTRL_OFS) begin
        rdata_reg <= ctrl_reg;
      end else if (i_bus.addr == timer_pkg::PERIOD_OFS) begin
        rdata_reg <= 16'(period_compare_reg);
      end else if (i_bus.addr == timer_pkg::DUTY_OFS) begin
        rdata_reg <= 16'(capture_duty_reg);
      end else if (i_bus.addr == timer_pkg::COUNT_OFS) begin
        rdata_reg <= 16'(cnt_reg);
      end else begin
        rdata_reg <= 16'h0000;
      end
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  // Output pin drives the inverse of the flop, so flop 0 gives a high pin.
  assign o_pulse_out_pin_n = ~output_toggle_flop;
  assign o_timer_match_irq = irq_reg;
  assign o_rdata           = rdata_reg;

  // Checks on counter, capture and output behaviour.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_win_inc;
    win && state_reg == timer_pkg::ST_RUN && running && gtick && !win_match && !ctrl_wr
      |=> cnt_reg == $past(cnt_reg) + 1'b1;
  endproperty
  a_win_inc: assert property (p_win_inc) else $error("window count missed a gated edge");

  property p_win_pol;
    win && ctrl_reg.start_edge_select == timer_pkg::SEL_FALL && pin_s2_reg |-> !gate;
  endproperty
  a_win_pol: assert property (p_win_pol) else $error("negative window counted while pin high");

  property p_win_clear;
    win_match && !ctrl_wr |=> cnt_reg == '0 && o_timer_match_irq;
  endproperty
  a_win_clear: assert property (p_win_clear) else $error("window match did not clear and interrupt");

  property p_meas_start;
    meas && running && state_reg == timer_pkg::ST_WAIT && trig && !ctrl_wr |=> state_reg == timer_pkg::ST_RUN;
  endproperty
  a_meas_start: assert property (p_meas_start) else $error("trigger edge did not start counting");

  property p_single_cap;
    cap_ev && single && opp && running && !ctrl_wr
      |=> capture_duty_reg == $past(cnt_reg) && o_timer_match_irq && cnt_reg == 16'h0001
          && state_reg == timer_pkg::ST_WAIT;
  endproperty
  a_single_cap: assert property (p_single_cap) else $error("single-edge capture wrong");

  property p_double_clr;
    cap_ev && !single && trig && !opp && running && !ctrl_wr
      |=> cnt_reg == '0 && o_timer_match_irq && state_reg == timer_pkg::ST_RUN;
  endproperty
  a_double_clr: assert property (p_double_clr) else $error("double-edge trigger did not clear");

  property p_duty_toggle;
    m_duty && !m_per |=> o_pulse_out_pin_n != $past(o_pulse_out_pin_n) ##1 o_pulse_out_pin_n == $past(o_pulse_out_pin_n);
  endproperty
  a_duty_toggle: assert property (p_duty_toggle) else $error("duty match did not toggle output");

  property p_oneshot;
    oneshot_done && !ctrl_wr |=> ctrl_reg.start_edge_select == timer_pkg::SEL_STOP
      ##1 state_reg == timer_pkg::ST_STOP && $stable(o_pulse_out_pin_n);
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot did not stop after period match");

  property p_stop_hold;
    !running && !ctrl_wr |=> $stable(output_toggle_flop);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("output moved while stopped");

  c_win_match:  cover property (win_match);
  c_single_cap: cover property (cap_ev && single);
  c_double_cap: cover property (cap_ev && !single ##[1:1000] cap_ev);
  c_oneshot:    cover property (oneshot_done);

endmodule : timer_window_capture_pulse_gen

`default_nettype wire

// file: sim/pin_pulse_src.sv
/*
  Pulse source that drives the timer input pin.
  Assumes it is clocked by the bench clock; widths are given in clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_pulse_src (
  input  wire logic        i_clk,
  input  wire logic        i_run,
  input  wire logic        i_level,
  input  wire logic [15:0] i_hi_cycles,
  input  wire logic [15:0] i_lo_cycles,
  output logic             o_pin
);
  logic [15:0] cnt_reg;

  // Stopped, the pin holds the requested level; running, it is high for i_hi_cycles and low for i_lo_cycles.
  always_ff @(posedge i_clk) begin
    if (!i_run) begin
      o_pin   <= i_level;
      cnt_reg <= 16'h0000;
    end else if (cnt_reg + 16'h0001 >= (o_pin ? i_hi_cycles : i_lo_cycles)) begin
      o_pin   <= ~o_pin;
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
endmodule : pin_pulse_src

`default_nettype wire

// file: sim/timer_window_capture_pulse_gen_tb.sv
/*
  Self-checking bench for the window, capture and pulse timer block.
  Assumes the timer package and the pin pulse source model; source clock code 3, code 2 in the slow source test.
*/
`timescale 1ns/1ps
`default_nettype none

module timer_window_capture_pulse_gen_tb;
  logic                i_clk = 1'b0;
  logic                i_rst = 1'b1;
  timer_pkg::bus_req_t bus   = '0;
  logic [15:0]         rdata, v, hi = 16'h0028, lo = 16'h0028;
  logic [15:0]         c [6];
  logic                pin, pin_n, irq, run = 1'b0, level = 1'b0;
  int                  err_total = 0, n_tests = 0, cyc = 0, irqs = 0, n, base;

  // Clock and the cycle and interrupt counters; the ceiling cuts a hang short.
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (irq === 1'b1) irqs++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  timer_window_capture_pulse_gen #(.CNT_W(16)) i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_bus(bus), .o_rdata(rdata),
    .i_timer_input_pin(pin), .o_pulse_out_pin_n(pin_n), .o_timer_match_irq(irq));
  pin_pulse_src i_src (.i_clk(i_clk), .i_run(run), .i_level(level), .i_hi_cycles(hi), .i_lo_cycles(lo), .o_pin(pin));

  // Register port write and read, one strobe cycle each.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_clk) bus <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_clk) bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge i_clk) bus <= '0;
    @(negedge i_clk) d = rdata;
  endtask : rd
  task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk
  task automatic rchk(input string s, input logic [7:0] a, input logic [15:0] exp);
    rd(a, v);
    chk(s, v, exp);
  endtask : rchk
  // Bounded waits for the next interrupt pulse or output pin change, counting cycles.
  task automatic wait_irq(output int k);
    k = 0;
    do begin
      @(negedge i_clk) k++;
    end while (irq !== 1'b1 && k < 500);
  endtask : wait_irq
  task automatic wait_pin(output int k);
    logic p;
    p = pin_n;
    k = 0;
    do begin
      @(negedge i_clk) k++;
    end while (pin_n === p && k < 500);
  endtask : wait_pin
  function automatic logic [15:0] mk(logic [2:0] m, logic [1:0] s, logic cap, logic rep, logic lvl);
    timer_pkg::ctrl_t t;
    t = '0;
    t.mode_field = m;
    t.start_edge_select = s;
    t.source_clock_select = 2'h3;
    t.capture_edge_mode = cap;
    t.pulse_repeat_mode = rep;
    t.output_initial_level = lvl;
    return t;
  endfunction : mk
  task automatic print_verdict();
    $display("tests %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  // Main sequence of tests.
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    chk("pin_reset", {15'h0000, pin_n}, 16'h0001);
    for (int i = 0; i < 4; i++) rchk("reg_reset", 8'(i * 4), 16'h0000);
    wr(timer_pkg::COUNT_OFS, 16'h1234);
    rchk("count_ro", timer_pkg::COUNT_OFS, 16'h0000);
    rchk("unmapped", 8'h10, 16'h0000);
    wr(timer_pkg::PERIOD_OFS, 16'hFFFF);
    rchk("period_width", timer_pkg::PERIOD_OFS, 16'hFFFF);
    $display("test registers done");
    // Window count with positive then negative logic.
    wr(timer_pkg::PERIOD_OFS, 16'h0005);
    for (int p = 0; p < 2; p++) begin
      @(posedge i_clk) level <= (p == 1);
      wr(timer_pkg::CTRL_OFS, mk(timer_pkg::MODE_WINDOW, p ? timer_pkg::SEL_FALL : timer_pkg::SEL_RISE, 0, 0, 0));
      repeat (30) @(posedge i_clk);
      rchk("win_idle", timer_pkg::COUNT_OFS, 16'h0000);
      @(posedge i_clk) level <= (p == 0);
      wait_irq(n);
      wait_irq(n);
      chk("win_period", 16'(n), 16'h000C);
      @(posedge i_clk) level <= (p == 1);
      repeat (10) @(posedge i_clk);
      rd(timer_pkg::COUNT_OFS, v);
      repeat (20) @(posedge i_clk);
      rchk("win_hold", timer_pkg::COUNT_OFS, v);
      wr(timer_pkg::CTRL_OFS, mk(timer_pkg::MODE_WINDOW, timer_pkg::SEL_STOP, 0, 0, 0));
    end
    $display("test window done");
    // Single-edge capture of 40-cycle high pulses.
    @(posedge i_clk) level <= 1'b0;
    wr(timer_pkg::CTRL_OFS, mk(timer_pkg::MODE_MEASURE, timer_pkg::SEL_RISE, 1, 0, 0));
    @(posedge i_clk) run <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wait_irq(n);
      rd(timer_pkg::DUTY_OFS, c[i]);
    end
    rchk("hold_one", timer_pkg::COUNT_OFS, 16'h0001);
    chk("cap_step", c[1], c[0] + 16'h0001);
    chk("cap_same", c[2], c[1]);
    // The read of the previous capture takes two of the measured cycles.
    chk("cap_gap", 16'(n + 2), 16'h0050);
    @(posedge i_clk) run <= 1'b0;
    wr(timer_pkg::CTRL_OFS, mk(timer_pkg::MODE_MEASURE, timer_pkg::SEL_STOP, 0, 0, 0));
    $display("test single capture done");
    // Double-edge capture: 40 cycles high, 60 low; the first pair is discarded.
    @(posedge i_clk) lo <= 16'h003C;
    wr(timer_pkg::CTRL_OFS, mk(timer_pkg::MODE_MEASURE, timer_pkg::SEL_RISE, 0, 0, 0));
    @(posedge i_clk) run <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      wait_irq(n);
      rd(timer_pkg::DUTY_OFS, c[i]);
    end
    chk("dbl_low", c[3] - c[2], 16'h001E);
    chk("dbl_high", c[4], c[2]);
    chk("dbl_cycle", c[5], c[3]);
    // The read of the previous capture takes two of the measured cycles.
    chk("dbl_gap", 16'(n + 2), 16'h003C);
    @(posedge i_clk) run <= 1'b0;
    wr(timer_pkg::CTRL_OFS, mk(timer_pkg::MODE_MEASURE, timer_pkg::SEL_STOP, 0, 0, 0));
    $display("test double capture done");
    // Continuous pulses by command start, duty 2, period 7, then a stop.
    wr(timer_pkg::CTRL_OFS, mk(timer_pkg::MODE_TIMER, timer_pkg::SEL_STOP, 0, 0, 0));
    wr(timer_pkg::CTRL_OFS, mk(timer_pkg::MODE_PULSE, timer_pkg::SEL_STOP, 0, 0, 0));
    wr(timer_pkg::DUTY_OFS, 16'h0002);
    wr(timer_pkg::PERIOD_OFS, 16'h0007);
    chk("ppg_init", {15'h0000, pin_n}, 16'h0001);
    base = irqs;
    wr(timer_pkg::CTRL_OFS, mk(timer_pkg::MODE_PULSE, timer_pkg::SEL_CMD, 0, 0, 0));
    wait_pin(n);
    wait_pin(n);
    chk("ppg_low", 16'(n), 16'h000A);
    wait_pin(n);
    chk("ppg_high", 16'(n), 16'h0006);
    repeat (2) @(posedge i_clk);
    chk("ppg_irqs", 16'(irqs - base), 16'h0003);
    wr(timer_pkg::CTRL_OFS, mk(timer_pkg::MODE_PULSE, timer_pkg::SEL_STOP, 0, 0, 0));
    repeat (40) @(posedge i_clk);
    chk("stop_hold", {15'h0000, pin_n}, 16'h0000);
    rchk("stop_count", timer_pkg::COUNT_OFS, 16'h0000);
    $display("test continuous pulse done");
    // One-shot pulse, low start level, started by a rising pin edge.
    wr(timer_pkg::CTRL_OFS, mk(timer_pkg::MODE_TIMER, timer_pkg::SEL_STOP, 0, 0, 0));
    wr(timer_pkg::CTRL_OFS, mk(timer_pkg::MODE_PULSE, timer_pkg::SEL_STOP, 0, 1, 0));
    @(negedge i_clk) chk("reinit_high", {15'h0000, pin_n}, 16'h0001);
    wr(timer_pkg::CTRL_OFS, mk(timer_pkg::MODE_TIMER, timer_pkg::SEL_STOP, 0, 0, 0));
    wr(timer_pkg::CTRL_OFS, mk(timer_pkg::MODE_PULSE, timer_pkg::SEL_STOP, 0, 1, 1));
    @(negedge i_clk) chk("shot_init", {15'h0000, pin_n}, 16'h0000);
    wr(timer_pkg::CTRL_OFS, mk(timer_pkg::MODE_PULSE, timer_pkg::SEL_RISE, 0, 1, 1));
    base = irqs;
    repeat (40) @(posedge i_clk);
    chk("shot_wait", {15'h0000, pin_n} | 16'(irqs - base), 16'h0000);
    @(posedge i_clk) level <= 1'b1;
    wait_pin(n);
    wait_pin(n);
    chk("shot_high", 16'(n), 16'h000A);
    repeat (40) @(posedge i_clk);
    chk("shot_hold", {15'h0000, pin_n}, 16'h0000);
    chk("shot_irqs", 16'(irqs - base), 16'h0002);
    rchk("shot_ctrl", timer_pkg::CTRL_OFS, mk(timer_pkg::MODE_PULSE, timer_pkg::SEL_STOP, 0, 1, 1));
    $display("test one-shot pulse done");
    // Window count on source clock code 2 (divide by 8), pin high, period 7: eight gated edges per match.
    wr(timer_pkg::CTRL_OFS, mk(timer_pkg::MODE_WINDOW, timer_pkg::SEL_RISE, 0, 0, 0) & ~16'h0020);
    wait_irq(n);
    wait_irq(n);
    chk("win_slow", 16'(n), 16'h0040);
    $display("test slow source done");
    print_verdict();
  end
endmodule : timer_window_capture_pulse_gen_tb

`default_nettype wire
